/* logic/pa_stage_pkg.sv */
// pa_stage_pkg: register map, field positions, reset values and enums
// for the power amplifier stage control block.
// assumes 8-bit registers on a 32-bit classic wishbone bus, one word each.
package pa_stage_pkg;

  // register indices as printed; byte address is four times the index
  localparam logic [7:0] IDX_TX_STATUS    = 8'h01;
  localparam logic [7:0] IDX_TX_CFG_ZERO  = 8'h04;
  localparam logic [7:0] IDX_TX_CFG_ONE   = 8'h05;
  localparam logic [7:0] IDX_SLOPE_DIV    = 8'h19;
  localparam logic [7:0] IDX_BLOCK_ENA    = 8'h1a;
  localparam logic [7:0] IDX_STAGE_CNT    = 8'h1b;
  localparam logic [7:0] IDX_ANT_DUTY     = 8'h1f;
  localparam logic [7:0] IDX_TX_CTRL      = 8'h20;

  // field positions
  localparam int FAILSAFE_DISARM_BIT = 4;
  localparam int SLOPING_ENABLE_BIT  = 4;
  localparam int FSK_SEL_ONE_BIT     = 5;
  localparam int FSK_SEL_TWO_BIT     = 6;
  localparam int DUTY_OFF_BIT        = 6;
  localparam int DUTY_SEL_LSB        = 4;
  localparam int CTRL_TX_ACTIVE_BIT  = 0;
  localparam int CTRL_SETUP_SEL_BIT  = 1;
  localparam int CTRL_BAND_315_BIT   = 2;
  localparam int ST_PARITY_BIT       = 0;
  localparam int ST_BROWNOUT_BIT     = 1;
  localparam int ST_LOCK_FAIL_BIT    = 2;
  localparam int ST_PA_KILLED_BIT    = 3;

  // reset values
  localparam logic [7:0] RST_TX_CFG_ZERO = 8'h0c;
  localparam logic [7:0] RST_TX_CFG_ONE  = 8'h25;
  localparam logic [7:0] RST_SLOPE_DIV   = 8'h80;
  localparam logic [7:0] RST_BLOCK_ENA   = 8'h00;
  localparam logic [7:0] RST_STAGE_CNT   = 8'h00;
  localparam logic [7:0] RST_ANT_DUTY    = 8'h00;
  localparam logic [7:0] RST_TX_CTRL     = 8'h00;

  // stage layout
  localparam int          NUM_STAGES     = 11;
  localparam int          BLOCK0_STAGES  = 9;
  localparam logic [3:0]  MAX_STAGE_CNT  = 4'd11;

  // duty cycle codes presented to the amplifier bias
  typedef enum logic [2:0] {
    DUTY_31 = 3'b000,
    DUTY_35 = 3'b001,
    DUTY_39 = 3'b010,
    DUTY_43 = 3'b011,
    DUTY_50 = 3'b100,
    DUTY_33 = 3'b101
  } duty_e;

  typedef enum logic [1:0] {
    RAMP_IDLE = 2'b00,
    RAMP_UP   = 2'b01,
    RAMP_DOWN = 2'b10
  } ramp_e;

  // amplifier drive bundle
  typedef struct packed {
    logic [10:0] stage_on;
    logic [2:0]  block_en;
    duty_e       duty;
    logic [3:0]  tune_caps;
  } pa_drive_s;

  // fail-safe error event bundle
  typedef struct packed {
    logic parity;
    logic brownout;
    logic lock_fail;
  } fault_s;

endpackage : pa_stage_pkg

/* logic/pa_stage_control.sv */
// pa_stage_control: power amplifier stage enables, ask sloping, duty cycle,
// antenna tuning switches and fail-safe switch-off, with wishbone registers.
// assumes tx_data_i and fault inputs come from other clock domains or pins;
// clk_i is the reference oscillator clock.
//
// Design decision made here: the Wishbone interface to the registers.
`timescale 1ns/1ps
module pa_stage_control
  import pa_stage_pkg::*;
(
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // wishbone slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [9:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  // transmit data and fault events, asynchronous
  input  wire logic        tx_data_i,
  input  wire fault_s      fault_i,
  // amplifier drive
  output pa_drive_s        pa_o
);

  // synchronisers
  logic       data_s1_q, data_s2_q;
  fault_s     flt_s1_q, flt_s2_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      data_s1_q <= 1'b0;
      data_s2_q <= 1'b0;
      flt_s1_q  <= '0;
      flt_s2_q  <= '0;
    end else begin
      data_s1_q <= tx_data_i;
      data_s2_q <= data_s1_q;
      flt_s1_q  <= fault_i;
      flt_s2_q  <= flt_s1_q;
    end
  end

  // registers
  logic [7:0] cfg0_q, cfg1_q, slope_q, blk_q, cnt_q, ant_q, ctrl_q;
  logic [2:0] err_q;
  logic       killed_q;
  logic       ack_q;
  logic [31:0] rdat_q;

  logic [7:0] idx;
  logic       wr_stb;
  logic       rd_stb;
  logic       hit;

  assign idx    = adr_i[9:2];
  // write lands on the edge where the master sees ack, while it still holds data
  assign wr_stb = cyc_i && stb_i && we_i && ack_q && sel_i[0];
  assign rd_stb = cyc_i && stb_i && !we_i && !ack_q;

  always_comb begin
    case (idx)
      IDX_TX_STATUS, IDX_TX_CFG_ZERO, IDX_TX_CFG_ONE, IDX_SLOPE_DIV,
      IDX_BLOCK_ENA, IDX_STAGE_CNT, IDX_ANT_DUTY, IDX_TX_CTRL: hit = 1'b1;
      default: hit = 1'b0;
    endcase
  end

  // one wait state; unmapped reads return zero, writes dropped
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= cyc_i && stb_i && !ack_q;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg0_q  <= RST_TX_CFG_ZERO;
      cfg1_q  <= RST_TX_CFG_ONE;
      slope_q <= RST_SLOPE_DIV;
      blk_q   <= RST_BLOCK_ENA;
      cnt_q   <= RST_STAGE_CNT;
      ant_q   <= RST_ANT_DUTY;
      ctrl_q  <= RST_TX_CTRL;
    end else if (wr_stb && hit) begin
      case (idx)
        IDX_TX_CFG_ZERO: cfg0_q  <= dat_i[7:0];
        IDX_TX_CFG_ONE:  cfg1_q  <= dat_i[7:0];
        IDX_SLOPE_DIV:   slope_q <= dat_i[7:0];
        IDX_BLOCK_ENA:   blk_q   <= dat_i[7:0];
        IDX_STAGE_CNT:   cnt_q   <= dat_i[7:0];
        IDX_ANT_DUTY:    ant_q   <= dat_i[7:0];
        IDX_TX_CTRL:     ctrl_q  <= dat_i[7:0];
        default:         ;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdat_q <= '0;
    end else if (rd_stb) begin
      case (idx)
        IDX_TX_STATUS:   rdat_q <= {24'h00_0000, 4'h0, killed_q, err_q};
        IDX_TX_CFG_ZERO: rdat_q <= {24'h00_0000, cfg0_q};
        IDX_TX_CFG_ONE:  rdat_q <= {24'h00_0000, cfg1_q};
        IDX_SLOPE_DIV:   rdat_q <= {24'h00_0000, slope_q};
        IDX_BLOCK_ENA:   rdat_q <= {24'h00_0000, blk_q};
        IDX_STAGE_CNT:   rdat_q <= {24'h00_0000, cnt_q};
        IDX_ANT_DUTY:    rdat_q <= {24'h00_0000, ant_q};
        IDX_TX_CTRL:     rdat_q <= {24'h00_0000, ctrl_q};
        default:         rdat_q <= '0;
      endcase
    end
  end

  assign ack_o = ack_q;
  assign dat_o = rdat_q;

  // status read clears error flags; a new event in that cycle wins
  logic tx_active, status_rd, armed;
  assign tx_active = ctrl_q[CTRL_TX_ACTIVE_BIT];
  assign status_rd = rd_stb && (idx == IDX_TX_STATUS);
  assign armed     = !cfg0_q[FAILSAFE_DISARM_BIT];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      err_q <= '0;
    end else begin
      err_q <= (status_rd ? 3'b000 : err_q)
             | {flt_s2_q.lock_fail, flt_s2_q.brownout, flt_s2_q.parity};
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      killed_q <= 1'b0;
    end else if (armed && tx_active && (flt_s2_q != '0)) begin
      killed_q <= 1'b1;
    end else if (!tx_active) begin
      killed_q <= 1'b0;
    end
  end

  // setup selection from the transmit command bit
  logic       use_two;
  logic [2:0] blk_sel;
  logic [3:0] cnt_sel;
  logic       is_fsk;
  assign use_two = ctrl_q[CTRL_SETUP_SEL_BIT];
  assign blk_sel = use_two ? blk_q[7:5] : blk_q[4:2];
  assign cnt_sel = use_two ? cnt_q[7:4] : cnt_q[3:0];
  assign is_fsk  = use_two ? cfg1_q[FSK_SEL_TWO_BIT] : cfg1_q[FSK_SEL_ONE_BIT];

  // available stages from block enables, then limited by count
  logic [3:0] avail;
  logic [3:0] target;
  always_comb begin
    avail = 4'd0;
    if (blk_sel[0]) avail = 4'(BLOCK0_STAGES);
    if (blk_sel[1]) avail = avail + 4'd1;
    if (blk_sel[2]) avail = avail + 4'd1;
    target = (cnt_sel < avail) ? cnt_sel : avail;
    if (target > MAX_STAGE_CNT) target = MAX_STAGE_CNT;
  end

  logic want_on;
  assign want_on = tx_active && !killed_q && (is_fsk || data_s2_q);

  // ramp: level counts stages lit, lower stages first
  ramp_e      state_q;
  logic [3:0] level_q;
  logic [7:0] div_q;
  logic       sloping;
  logic [3:0] goal;
  assign sloping = cfg1_q[SLOPING_ENABLE_BIT] && !is_fsk;
  assign goal    = want_on ? target : 4'd0;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= RAMP_IDLE;
      level_q <= 4'd0;
      div_q   <= 8'h00;
    end else if (killed_q || !sloping) begin
      // fault kill is immediate, never ramped
      state_q <= RAMP_IDLE;
      level_q <= killed_q ? 4'd0 : goal;
      div_q   <= 8'h00;
    end else begin
      case (state_q)
        RAMP_IDLE: begin
          div_q <= slope_q;
          if (goal > level_q)      state_q <= RAMP_UP;
          else if (goal < level_q) state_q <= RAMP_DOWN;
        end
        RAMP_UP, RAMP_DOWN: begin
          // divider n gives n cycles per step; 0 and 1 both step every cycle
          if (div_q > 8'h01) begin
            div_q <= div_q - 8'h01;
          end else begin
            div_q <= slope_q;
            if (goal > level_q)      level_q <= level_q + 4'd1;
            else if (goal < level_q) level_q <= level_q - 4'd1;
            if (goal == level_q) state_q <= RAMP_IDLE;
          end
        end
        default: state_q <= RAMP_IDLE;
      endcase
    end
  end

  // stage i lit when its block enabled and its rank among enabled stages below level
  logic [10:0] stage_mask;
  genvar g;
  generate
    for (g = 0; g < NUM_STAGES; g++) begin : g_stage
      always_comb begin
        if (g < BLOCK0_STAGES)
          stage_mask[g] = blk_sel[0] && (4'(g) < level_q);
        else if (g == BLOCK0_STAGES)
          stage_mask[g] = blk_sel[1] && (4'(g) < level_q
                          || (!blk_sel[0] && level_q != 4'd0));
        else
          stage_mask[g] = blk_sel[2] && (level_q >= avail)
                          && (level_q != 4'd0);
      end
    end
  endgenerate

  // duty select
  duty_e duty_d;
  always_comb begin
    if (ctrl_q[CTRL_BAND_315_BIT])   duty_d = DUTY_33;
    else if (ant_q[DUTY_OFF_BIT])    duty_d = DUTY_50;
    else begin
      case (ant_q[DUTY_SEL_LSB +: 2])
        2'b00:   duty_d = DUTY_31;
        2'b01:   duty_d = DUTY_35;
        2'b10:   duty_d = DUTY_39;
        default: duty_d = DUTY_43;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pa_o <= '{stage_on: '0, block_en: '0, duty: DUTY_50, tune_caps: '0};
    end else begin
      pa_o.stage_on  <= killed_q ? 11'h000 : stage_mask;
      pa_o.block_en  <= (killed_q || level_q == 4'd0) ? 3'b000 : blk_sel;
      pa_o.duty      <= duty_d;
      pa_o.tune_caps <= ant_q[3:0];
    end
  end

endmodule : pa_stage_control

/* tb/pa_load_model.sv */
// pa_load_model: amplifier cells seen through the drive bundle.
// assumes stage_on alone sets how many cells conduct.
`timescale 1ns/1ps
module pa_load_model
  import pa_stage_pkg::*;
(
  // amplifier drive
  input  wire pa_drive_s pa_i,
  // output power step
  output logic [3:0]     lit_o
);
  // power step is the lit cell count; zero means a silent amplifier
  assign lit_o = 4'($countones(pa_i.stage_on));
endmodule : pa_load_model

/* tb/pa_stage_asserts.sv */
// pa_stage_asserts: port checks for pa_stage_control.
// assumes a classic wishbone master that holds requests until ack.
`timescale 1ns/1ps
module pa_stage_asserts
  import pa_stage_pkg::*;
(
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic        we_i,
  input wire logic [9:0]  adr_i,
  input wire logic [3:0]  sel_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic        ack_o,
  input wire logic        tx_data_i,
  input wire fault_s      fault_i,
  input wire pa_drive_s   pa_o
);
  logic disarm_q;
  // snooped disarm bit, so the kill check knows when it applies
  always_ff @(posedge clk_i) begin
    if (rst_i)
      disarm_q <= 1'b0;
    else if (cyc_i && stb_i && we_i && ack_o && sel_i[0] && adr_i[9:2] == IDX_TX_CFG_ZERO)
      disarm_q <= dat_i[FAILSAFE_DISARM_BIT];
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  ack_req_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o) else $error("no ack");
  ack_pulse_a: assert property (ack_o |=> !ack_o) else $error("ack held");
  read_pad_a: assert property (ack_o |-> dat_o[31:8] == 24'h00_0000) else $error("pad");
  reset_out_a: assert property ($fell(rst_i) |-> pa_o.stage_on == 11'h000)
    else $error("drive after reset");
  blk_nine_a: assert property (|pa_o.stage_on[8:0] |-> pa_o.block_en[0])
    else $error("block zero");
  blk_ten_a: assert property (pa_o.stage_on[9] |-> pa_o.block_en[1])
    else $error("tenth stage");
  blk_top_a: assert property (pa_o.stage_on[10] |-> pa_o.block_en[2])
    else $error("eleventh stage");
  lit_order_a: assert property (((pa_o.stage_on[8:0] + 9'h001) & pa_o.stage_on[8:0]) == 9'h000)
    else $error("lit order");
  fail_off_a: assert property ((!disarm_q && |fault_i)[*8] |=> pa_o.stage_on == 11'h000)
    else $error("fault kill");
endmodule : pa_stage_asserts
bind pa_stage_control pa_stage_asserts chk (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
  .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
  .ack_o(ack_o), .tx_data_i(tx_data_i), .fault_i(fault_i), .pa_o(pa_o));

/* tb/testbench.sv */
// testbench: register, power level, duty, sloping and fault scenarios.
// assumes a 200 MHz clock and outputs seen five clocks after data.
`timescale 1ns/1ps
module testbench;
  import pa_stage_pkg::*;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [9:0]  adr = '0;
  logic [3:0]  sel = '0;
  logic [31:0] dwr = '0;
  logic [31:0] dat_o;
  logic        ack;
  logic        txd = 1'b0;
  fault_s      flt = '0;
  pa_drive_s   pa;
  logic [3:0]  lit;
  logic [7:0]  rdv;
  int          fails = 0;
  int          n_checks = 0;
  logic [7:0]  ridx [9] = '{IDX_TX_STATUS, IDX_TX_CFG_ZERO, IDX_TX_CFG_ONE, IDX_SLOPE_DIV,
                 IDX_BLOCK_ENA, IDX_STAGE_CNT, IDX_ANT_DUTY, IDX_TX_CTRL, 8'h30};
  logic [7:0]  rrst [9] = '{8'h00, RST_TX_CFG_ZERO, RST_TX_CFG_ONE, RST_SLOPE_DIV,
                 RST_BLOCK_ENA, RST_STAGE_CNT, RST_ANT_DUTY, RST_TX_CTRL, 8'h00};
  always #2.5 clk_i = ~clk_i;
  pa_stage_control DUT (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we),
    .adr_i(adr), .sel_i(sel), .dat_i(dwr), .dat_o(dat_o), .ack_o(ack), .tx_data_i(txd),
    .fault_i(flt), .pa_o(pa));
  pa_load_model amp (.pa_i(pa), .lit_o(lit));
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask : tick
  task automatic chk(input logic [10:0] seen, input logic [10:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wb(input logic w, input logic [7:0] idx, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {idx, 2'b00};
    sel <= 4'hf;
    dwr <= {24'h00_0000, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 40);
    chk(11'(ack), 11'h001);
    rdv = dat_o[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb
  task automatic rd(input logic [7:0] idx, input logic [7:0] e);
    wb(1'b0, idx, 8'h00);
    chk(11'(rdv), 11'(e));
  endtask : rd
  // steps two clocks apart by the divider; a stall of 600 clocks counts as a miss
  task automatic ramp(input logic [10:0] a, input logic [10:0] b, input logic [10:0] c);
    logic [10:0] e [3];
    logic [10:0] prev;
    int          n;
    e = '{a, b, c};
    prev = pa.stage_on;
    for (int k = 0; k < 3; k++) begin
      n = 0;
      do begin
        @(posedge clk_i);
        n++;
      end while (pa.stage_on === prev && n < 600);
      prev = pa.stage_on;
      chk(prev, e[k]);
      if (k > 0) chk(11'(n), 11'h002);
    end
  endtask : ramp
  task automatic final_report;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : final_report
  initial begin
    tick(20000);
    fails++;
    final_report;
  end
  initial begin
    tick(12);
    rst_i <= 1'b0;
    wb(1'b1, 8'h30, 8'hff);
    foreach (ridx[i]) rd(ridx[i], rrst[i]);
    $display("test registers done");
    wb(1'b1, IDX_TX_CFG_ONE, 8'h00);
    wb(1'b1, IDX_BLOCK_ENA, 8'h3c);
    wb(1'b1, IDX_STAGE_CNT, 8'hb5);
    wb(1'b1, IDX_TX_CTRL, 8'h01);
    txd <= 1'b1;
    tick(5);
    chk(pa.stage_on, 11'h01f);
    chk(11'(pa.block_en), 11'h007);
    txd <= 1'b0;
    tick(5);
    chk(pa.stage_on, 11'h000);
    wb(1'b1, IDX_TX_CTRL, 8'h03);
    txd <= 1'b1;
    tick(5);
    chk(pa.stage_on, 11'h1ff);
    chk(11'(pa.block_en), 11'h001);
    wb(1'b1, IDX_TX_CFG_ONE, 8'h40);
    txd <= 1'b0;
    tick(5);
    chk(pa.stage_on, 11'h1ff);
    wb(1'b1, IDX_STAGE_CNT, 8'h05);
    tick(5);
    chk(11'(lit), 11'h000);
    $display("test power levels done");
    for (int c = 0; c < 4; c++) begin
      wb(1'b1, IDX_ANT_DUTY, 8'(c * 16 + (15 >> c)));
      tick(5);
      chk(11'(pa.duty), 11'(c));
      chk(11'(pa.tune_caps), 11'(15 >> c));
    end
    wb(1'b1, IDX_ANT_DUTY, 8'h40);
    tick(5);
    chk(11'(pa.duty), 11'(DUTY_50));
    wb(1'b1, IDX_ANT_DUTY, 8'h10);
    wb(1'b1, IDX_TX_CTRL, 8'h05);
    tick(5);
    chk(11'(pa.duty), 11'(DUTY_33));
    $display("test duty done");
    wb(1'b1, IDX_TX_CFG_ONE, 8'h10);
    wb(1'b1, IDX_SLOPE_DIV, 8'h02);
    wb(1'b1, IDX_STAGE_CNT, 8'h03);
    wb(1'b1, IDX_TX_CTRL, 8'h01);
    tick(4);
    txd <= 1'b1;
    ramp(11'h001, 11'h003, 11'h007);
    txd <= 1'b0;
    ramp(11'h003, 11'h001, 11'h000);
    $display("test sloping done");
    wb(1'b1, IDX_TX_CFG_ONE, 8'h00);
    wb(1'b1, IDX_STAGE_CNT, 8'h0b);
    txd <= 1'b1;
    tick(5);
    chk(pa.stage_on, 11'h7ff);
    flt <= 3'b100;
    tick(10);
    chk(pa.stage_on, 11'h000);
    flt <= 3'b000;
    tick(6);
    chk(pa.stage_on, 11'h000);
    rd(IDX_TX_STATUS, 8'h09);
    wb(1'b1, IDX_TX_CFG_ZERO, 8'h1c);
    wb(1'b1, IDX_TX_CTRL, 8'h00);
    wb(1'b1, IDX_TX_CTRL, 8'h01);
    tick(4);
    flt <= 3'b010;
    tick(10);
    chk(pa.stage_on, 11'h7ff);
    flt <= 3'b000;
    rd(IDX_TX_STATUS, 8'h02);
    $display("test fail-safe done");
    final_report;
  end
endmodule : testbench
